// ==== rtl/status_event_pkg.sv ====
package status_event_pkg;

  // Register width and value range
  localparam int          REG_W       = 16;
  localparam logic [15:0] VALUE_MASK  = 16'h7fff;
  localparam logic [15:0] RESET_ZERO  = 16'h0000;

  // Command port register indices
  localparam logic [3:0] ACT_COND_IDX = 4'h0;
  localparam logic [3:0] ACT_EVT_IDX  = 4'h1;
  localparam logic [3:0] ACT_EN_IDX   = 4'h2;
  localparam logic [3:0] ACT_FALL_IDX = 4'h3;
  localparam logic [3:0] ACT_RISE_IDX = 4'h4;
  localparam logic [3:0] FLT_COND_IDX = 4'h5;
  localparam logic [3:0] FLT_EVT_IDX  = 4'h6;
  localparam logic [3:0] FLT_EN_IDX   = 4'h7;
  localparam logic [3:0] FLT_FALL_IDX = 4'h8;
  localparam logic [3:0] FLT_RISE_IDX = 4'h9;

  // Activity condition bit positions
  localparam int CALIBRATING_BIT    = 0;
  localparam int AWAIT_TRIG_BIT     = 5;
  localparam int VOLT_REG_BIT       = 8;
  localparam int CURR_LIMIT_BIT     = 10;

  // Fault condition bit positions
  localparam int HIGH_OUT_TRIP_BIT  = 0;
  localparam int EXCESS_CURR_BIT    = 1;
  localparam int THERMAL_BIT        = 4;
  localparam int INHIBIT_BIT        = 9;
  localparam int LOOSE_OUT_BIT      = 10;

  // Defined bits, also the rising filter preset values
  localparam logic [15:0] ACT_DEFINED = 16'h0521;
  localparam logic [15:0] FLT_DEFINED = 16'h0613;

  // Status byte summary positions
  localparam int ACT_SUMMARY_POS = 7;
  localparam int FLT_SUMMARY_POS = 3;

endpackage

// ==== rtl/status_event_aggregator.sv ====
`timescale 1ns/1ps
`default_nettype none

module event_group
  import status_event_pkg::*;
#(
  parameter logic [15:0] DEFINED = 16'h0000
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] cond_in,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        wr_fall,
  input  wire logic        wr_rise,
  input  wire logic        rd_event,
  input  wire logic        preset,
  output logic      [15:0] cond,
  output logic      [15:0] event_r,
  output logic      [15:0] enable_r,
  output logic      [15:0] fall_r,
  output logic      [15:0] rise_r,
  output logic             summary_r
);

  logic [15:0] prev_r;
  logic [15:0] rise_hit;
  logic [15:0] fall_hit;
  logic [15:0] write_hit;
  logic [15:0] hits;
  logic [15:0] rise_nxt;
  logic [15:0] fall_nxt;
  logic [15:0] event_nxt;

  assign cond = cond_in & DEFINED;

  // Previous condition for edge detection
  // clock-to-clock compare
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= RESET_ZERO;
    end else begin
      prev_r <= cond;
    end
  end

  assign rise_hit = ~prev_r & cond & rise_r;
  // falling edge filter; both set gives either edge
  assign fall_hit = prev_r & ~cond & fall_r;

  // Next filter values, preset wins over a write
  always_comb begin
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    if (preset) begin
      // defined rising bits set, falling cleared
      rise_nxt = DEFINED;
      fall_nxt = RESET_ZERO;
    end else begin
      if (wr_rise) begin
        rise_nxt = wdata & VALUE_MASK;
      end
      if (wr_fall) begin
        fall_nxt = wdata & VALUE_MASK;
      end
    end
  end

  // newly enabled edges fire from present condition
  assign write_hit = ((rise_nxt & ~rise_r & cond) | (fall_nxt & ~fall_r & ~cond)) & DEFINED;
  assign hits = rise_hit | fall_hit | write_hit;

  // read clears, new hits still land
  assign event_nxt = (rd_event ? RESET_ZERO : event_r) | hits;

  // Filter registers
  // read/write filters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_r <= RESET_ZERO;
      fall_r <= RESET_ZERO;
    end else begin
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  // Enable mask
  // 15-bit mask, reset zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= RESET_ZERO;
    end else if (preset) begin
      enable_r <= RESET_ZERO;
    end else if (wr_en) begin
      enable_r <= wdata & VALUE_MASK;
    end
  end

  // Latched events
  // sticky until read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_r <= RESET_ZERO;
    end else begin
      event_r <= event_nxt;
    end
  end

  // Summary bit
  // OR of enabled events
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      summary_r <= 1'b0;
    end else begin
      summary_r <= |(event_r & enable_r);
    end
  end

  // Checks
  a_rise_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |rise_hit |=> (event_r & $past(rise_hit)) == $past(rise_hit))
    else $error("rising edge not latched");
  a_fall_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |fall_hit |=> (event_r & $past(fall_hit)) == $past(fall_hit))
    else $error("falling edge not latched");
  a_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_event && |hits |=> event_r == $past(hits))
    else $error("event lost on clearing read");
  a_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_event && hits == 16'h0000 |=> event_r == 16'h0000)
    else $error("event not cleared by read");
  a_no_filter: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_rise && !wr_fall && !preset
    |=> (event_r & ~$past(event_r) & ~$past(rise_r | fall_r)) == 16'h0000)
    else $error("event set with filter clear");
  a_unused_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (event_r & ~DEFINED) == 16'h0000 && (cond & ~DEFINED) == 16'h0000)
    else $error("unused bit set");
  a_summary_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 summary_r == $past(|(event_r & enable_r)))
    else $error("summary mismatch");
  a_preset_vals: assert property (@(posedge sys_clk) disable iff (!rst_n)
    preset |=> rise_r == DEFINED && fall_r == 16'h0000 && enable_r == 16'h0000)
    else $error("preset values wrong");
  a_write_event: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_rise && !preset
    |=> (event_r & $past(wdata & ~rise_r & cond)) == $past(wdata & ~rise_r & cond))
    else $error("filter write did not fire");
  a_range_top: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !enable_r[15] && !rise_r[15] && !fall_r[15])
    else $error("bit 15 stored");

  c_rise_seen: cover property (@(posedge sys_clk) disable iff (!rst_n) |rise_hit);
  c_fall_seen: cover property (@(posedge sys_clk) disable iff (!rst_n) |fall_hit);
  c_read_race: cover property (@(posedge sys_clk) disable iff (!rst_n) rd_event && |hits);
  c_summary:   cover property (@(posedge sys_clk) disable iff (!rst_n) summary_r);

endmodule

module status_event_aggregator
  import status_event_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        calibrating_flag,
  input  wire logic        current_limited_flag,
  input  wire logic        voltage_regulated_flag,
  input  wire logic        awaiting_trigger_flag,
  input  wire logic        high_output_trip_flag,
  input  wire logic        excess_current_trip_flag,
  input  wire logic        thermal_alarm_flag,
  input  wire logic        inhibit_input_flag,
  input  wire logic        output_loose_flag,
  input  wire logic [3:0]  cmd_addr,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        filter_preset_command,
  output logic      [15:0] cmd_rdata,
  output logic             cmd_rvalid,
  output logic             activity_summary_bit,
  output logic             fault_summary_bit
);

  logic        rst_meta_r;
  logic        rst_sync_r;
  logic [15:0] act_cond_in;
  logic [15:0] flt_cond_in;
  logic [15:0] act_cond;
  logic [15:0] act_evt;
  logic [15:0] act_en;
  logic [15:0] act_fall;
  logic [15:0] act_rise;
  logic [15:0] flt_cond;
  logic [15:0] flt_evt;
  logic [15:0] flt_en;
  logic [15:0] flt_fall;
  logic [15:0] flt_rise;
  logic [15:0] rdata_nxt;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Activity condition word
  always_comb begin
    act_cond_in = RESET_ZERO;
    act_cond_in[CALIBRATING_BIT] = calibrating_flag;
    act_cond_in[CURR_LIMIT_BIT]  = current_limited_flag;
    act_cond_in[VOLT_REG_BIT]    = voltage_regulated_flag;
    act_cond_in[AWAIT_TRIG_BIT]  = awaiting_trigger_flag;
  end

  // Fault condition word
  always_comb begin
    flt_cond_in = RESET_ZERO;
    flt_cond_in[HIGH_OUT_TRIP_BIT] = high_output_trip_flag;
    flt_cond_in[EXCESS_CURR_BIT]   = excess_current_trip_flag;
    flt_cond_in[THERMAL_BIT]       = thermal_alarm_flag;
    flt_cond_in[INHIBIT_BIT]       = inhibit_input_flag;
    flt_cond_in[LOOSE_OUT_BIT]     = output_loose_flag;
  end

  event_group #(.DEFINED(ACT_DEFINED)) u_activity (
    .sys_clk   (sys_clk),
    .rst_n     (rst_sync_r),
    .cond_in   (act_cond_in),
    .wdata     (cmd_wdata),
    .wr_en     (cmd_wr && cmd_addr == ACT_EN_IDX),
    .wr_fall   (cmd_wr && cmd_addr == ACT_FALL_IDX),
    .wr_rise   (cmd_wr && cmd_addr == ACT_RISE_IDX),
    .rd_event  (cmd_rd && cmd_addr == ACT_EVT_IDX),
    .preset    (filter_preset_command),
    .cond      (act_cond),
    .event_r   (act_evt),
    .enable_r  (act_en),
    .fall_r    (act_fall),
    .rise_r    (act_rise),
    .summary_r (activity_summary_bit)
  );

  event_group #(.DEFINED(FLT_DEFINED)) u_fault (
    .sys_clk   (sys_clk),
    .rst_n     (rst_sync_r),
    .cond_in   (flt_cond_in),
    .wdata     (cmd_wdata),
    .wr_en     (cmd_wr && cmd_addr == FLT_EN_IDX),
    .wr_fall   (cmd_wr && cmd_addr == FLT_FALL_IDX),
    .wr_rise   (cmd_wr && cmd_addr == FLT_RISE_IDX),
    .rd_event  (cmd_rd && cmd_addr == FLT_EVT_IDX),
    .preset    (filter_preset_command),
    .cond      (flt_cond),
    .event_r   (flt_evt),
    .enable_r  (flt_en),
    .fall_r    (flt_fall),
    .rise_r    (flt_rise),
    .summary_r (fault_summary_bit)
  );

  // Read select, unmapped reads zero
  always_comb begin
    case (cmd_addr)
      ACT_COND_IDX: rdata_nxt = act_cond;
      ACT_EVT_IDX:  rdata_nxt = act_evt;
      ACT_EN_IDX:   rdata_nxt = act_en;
      ACT_FALL_IDX: rdata_nxt = act_fall;
      ACT_RISE_IDX: rdata_nxt = act_rise;
      FLT_COND_IDX: rdata_nxt = flt_cond;
      FLT_EVT_IDX:  rdata_nxt = flt_evt;
      FLT_EN_IDX:   rdata_nxt = flt_en;
      FLT_FALL_IDX: rdata_nxt = flt_fall;
      FLT_RISE_IDX: rdata_nxt = flt_rise;
      default:      rdata_nxt = RESET_ZERO;
    endcase
  end

  // Read data register
  always_ff @(posedge sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cmd_rdata  <= RESET_ZERO;
      cmd_rvalid <= 1'b0;
    end else begin
      cmd_rvalid <= cmd_rd;
      if (cmd_rd) begin
        cmd_rdata <= rdata_nxt;
      end
    end
  end

  a_cond_read: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    cmd_rd && cmd_addr == ACT_COND_IDX |=> cmd_rvalid && cmd_rdata == $past(act_cond_in & ACT_DEFINED))
    else $error("condition read not live");
  a_evt_read: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    cmd_rd && cmd_addr == FLT_EVT_IDX |=> cmd_rdata == $past(flt_evt))
    else $error("fault event read wrong");
  a_preset_nums: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    filter_preset_command |=> act_rise == 16'h0521 && flt_rise == 16'h0613)
    else $error("preset rising values wrong");
  a_fault_sum: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    ##1 fault_summary_bit == $past(|(flt_evt & flt_en)))
    else $error("fault summary wrong");

  c_preset: cover property (@(posedge sys_clk) disable iff (!rst_sync_r) filter_preset_command);

endmodule

`default_nettype wire

// ==== test/status_event_aggregator_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module status_event_aggregator_tb
  import status_event_pkg::*;
;
  typedef struct packed {
    logic        g;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] c0;
    logic [15:0] c1;
    logic [15:0] ev;
  } row_type;

  logic        sys_clk;
  logic        rst_n;
  logic [15:0] acond;
  logic [15:0] fcond;
  logic [3:0]  cmd_addr;
  logic        cmd_wr;
  logic        cmd_rd;
  logic [15:0] cmd_wdata;
  logic        filter_preset_command;
  logic [15:0] cmd_rdata;
  logic        cmd_rvalid;
  logic        activity_summary_bit;
  logic        fault_summary_bit;
  logic [15:0] q;
  row_type     r;
  int          bad_count;
  int          total_checks;

  // Filter cases: group, rising, falling, start, end, expected events
  row_type rows [8] = '{
    '{1'b0, 16'h0521, 16'h0000, 16'h0000, 16'h0521, 16'h0521},
    '{1'b0, 16'h0000, 16'h0521, 16'h0521, 16'h0000, 16'h0521},
    '{1'b0, 16'h0521, 16'h0521, 16'h0101, 16'h0420, 16'h0521},
    '{1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0521, 16'h0000},
    '{1'b1, 16'h0613, 16'h0000, 16'h0000, 16'h0613, 16'h0613},
    '{1'b1, 16'h0000, 16'h0613, 16'h0613, 16'h0000, 16'h0613},
    '{1'b1, 16'h0001, 16'h0010, 16'h0010, 16'h0001, 16'h0011},
    '{1'b1, 16'h7fff, 16'h7fff, 16'h0000, 16'hffff, 16'h0613}
  };
  logic [3:0] zero_idx [4] = '{ACT_EN_IDX, ACT_FALL_IDX, FLT_EN_IDX, FLT_FALL_IDX};

  status_event_aggregator uut (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .calibrating_flag         (acond[0]),
    .current_limited_flag     (acond[10]),
    .voltage_regulated_flag   (acond[8]),
    .awaiting_trigger_flag    (acond[5]),
    .high_output_trip_flag    (fcond[0]),
    .excess_current_trip_flag (fcond[1]),
    .thermal_alarm_flag       (fcond[4]),
    .inhibit_input_flag       (fcond[9]),
    .output_loose_flag        (fcond[10]),
    .cmd_addr                 (cmd_addr),
    .cmd_wr                   (cmd_wr),
    .cmd_rd                   (cmd_rd),
    .cmd_wdata                (cmd_wdata),
    .filter_preset_command    (filter_preset_command),
    .cmd_rdata                (cmd_rdata),
    .cmd_rvalid               (cmd_rvalid),
    .activity_summary_bit     (activity_summary_bit),
    .fault_summary_bit        (fault_summary_bit)
  );

  // Free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cmd_addr  = a;
    cmd_wdata = d;
    cmd_wr    = 1'b1;
    tick(1);
    cmd_wr = 1'b0;
    tick(1);
  endtask

  // Read strobe one cycle; data and valid are due right after the taking edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    cmd_addr = a;
    cmd_rd   = 1'b1;
    tick(1);
    d = cmd_rdata;
    chk({15'h0000, cmd_rvalid}, 16'h0001);
    cmd_rd = 1'b0;
    tick(1);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  // Guard against a hung run
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    bad_count = 0;
    total_checks = 0;
    rst_n = 1'b0;
    acond = 16'h0000;
    fcond = 16'h0000;
    cmd_addr = 4'h0;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 16'h0000;
    filter_preset_command = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(3);
    // Table of filter cases, one group at a time
    foreach (rows[i]) begin
      r = rows[i];
      acond = r.g ? 16'h0000 : r.c0;
      fcond = r.g ? r.c0 : 16'h0000;
      tick(2);
      wr(r.g ? FLT_RISE_IDX : ACT_RISE_IDX, r.rise);
      wr(r.g ? FLT_FALL_IDX : ACT_FALL_IDX, r.fall);
      tick(2);
      rd(r.g ? FLT_EVT_IDX : ACT_EVT_IDX, q);
      if (r.g) fcond = r.c1;
      else acond = r.c1;
      tick(3);
      rdc(r.g ? FLT_EVT_IDX : ACT_EVT_IDX, r.ev);
      rdc(r.g ? FLT_COND_IDX : ACT_COND_IDX, r.c1 & (r.g ? FLT_DEFINED : ACT_DEFINED));
    end
    acond = 16'h0000;
    fcond = 16'h0000;
    tick(3);
    rd(ACT_EVT_IDX, q);
    rd(FLT_EVT_IDX, q);
    // filter write raises event, masked then enabled summary
    acond = 16'h0020;
    tick(2);
    wr(ACT_RISE_IDX, 16'h0020);
    tick(2);
    chk({15'h0000, activity_summary_bit}, 16'h0000);
    wr(ACT_EN_IDX, 16'h0020);
    tick(2);
    chk({15'h0000, activity_summary_bit}, 16'h0001);
    rdc(ACT_EVT_IDX, 16'h0020);
    tick(2);
    chk({15'h0000, activity_summary_bit}, 16'h0000);
    rdc(ACT_EVT_IDX, 16'h0000);
    // fault summary follows enabled fault events
    wr(FLT_EN_IDX, 16'h0010);
    fcond = 16'h0010;
    tick(3);
    chk({15'h0000, fault_summary_bit}, 16'h0001);
    rdc(FLT_EVT_IDX, 16'h0010);
    tick(2);
    chk({15'h0000, fault_summary_bit}, 16'h0000);
    // event landing on the clearing read survives
    wr(ACT_RISE_IDX, 16'h0521);
    // Condition change and clearing read share one edge
    acond = 16'h0021;
    rdc(ACT_EVT_IDX, 16'h0000);
    rdc(ACT_EVT_IDX, 16'h0001);
    wr(ACT_FALL_IDX, 16'hffff);
    rdc(ACT_FALL_IDX, 16'h7fff);
    wr(FLT_EN_IDX, 16'h8005);
    rdc(FLT_EN_IDX, 16'h0005);
    wr(ACT_COND_IDX, 16'h1234);
    rdc(ACT_COND_IDX, 16'h0021);
    rdc(4'hf, 16'h0000);
    // preset wins over a same-cycle write
    cmd_addr = ACT_RISE_IDX;
    cmd_wdata = 16'h0001;
    cmd_wr = 1'b1;
    filter_preset_command = 1'b1;
    tick(1);
    cmd_wr = 1'b0;
    filter_preset_command = 1'b0;
    tick(1);
    rdc(ACT_RISE_IDX, 16'h0521);
    rdc(FLT_RISE_IDX, 16'h0613);
    foreach (zero_idx[j]) rdc(zero_idx[j], 16'h0000);
    // Mid-run reset clears everything
    acond = 16'h0000;
    fcond = 16'h0000;
    rst_n = 1'b0;
    tick(2);
    chk({13'h0000, cmd_rvalid, activity_summary_bit, fault_summary_bit}, 16'h0000);
    rst_n = 1'b1;
    // Internal reset needs two edges, then a margin before commands
    tick(4);
    for (int k = 0; k < 10; k++) rdc(k[3:0], 16'h0000);
    stop_test();
  end
endmodule

`default_nettype wire
